// ---- test/phase_current_pwm_overcurrent_bench.sv ----
// self-checking bench: sensor and controller facing each other, plus a tied sensor
`default_nettype none
module phase_current_pwm_overcurrent_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 312;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic signed [11:0] vin_mv = 12'sh000;
    logic signed [11:0] vin2_mv = 12'sh000;
    logic oc_clear = 1'b0;
    logic res_ready = 1'b0;
    logic oc_latched, chan_two, oc_latched2, chan_two2, oc_flag, res_valid, res_ch2, overrun;
    logic [15:0] res_rel, res_per;
    int n_errors = 0;
    int samples_checked = 0;
    sense_link_if #(.TIED(1'b0)) link ();
    sense_link_if #(.TIED(1'b1)) link2 ();
    always #4 i_clk = ~i_clk;
    // tied link follows the main alignment; nobody else sinks its duty line
    initial begin
        link2.sync = 1'b0;
        link2.pwm_host_oe = 1'b0;
    end
    always @(posedge i_clk) begin
        link2.sync <= link.sync;
    end
    pwm_current_sensor i_pwm_current_sensor (.i_clk(i_clk),
        .i_rst(i_rst), .i_vin_mv(vin_mv), .link(link), .o_oc_latched(oc_latched), .o_channel_two(chan_two));
    pwm_current_sensor i_pwm_current_sensor_tied (.i_clk(i_clk),
        .i_rst(i_rst), .i_vin_mv(vin2_mv), .link(link2), .o_oc_latched(oc_latched2), .o_channel_two(chan_two2));
    motor_ctrl_end #(.SYNC_HZ(200000)) i_motor_ctrl_end (.i_clk(i_clk), .i_rst(i_rst), .link(link),
        .i_oc_clear(oc_clear), .o_oc_flag(oc_flag), .o_res_valid(res_valid), .i_res_ready(res_ready),
        .o_res_channel_two(res_ch2), .o_res_released(res_rel), .o_res_period(res_per), .o_overrun(overrun));
    sense_link_properties #(.HALF(HALF)) i_sense_link_properties (.i_clk(i_clk), .i_rst(i_rst), .sync(link.sync),
        .pwm_dev_oe(link.pwm_dev_oe), .pwm_host_oe(link.pwm_host_oe), .flag_oe(link.flag_oe),
        .pwm_line(link.pwm_line), .flag_line(link.flag_line));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checked %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // bounded wait on a flag sink; running out ends the run
    task automatic wait_flag(input logic tied, input logic val, input int bound);
        int k;
        k = 0;
        while (((tied ? link2.flag_oe : link.flag_oe) !== val) && k < bound) begin
            @(posedge i_clk);
            k++;
        end
        if (k >= bound) begin
            check({31'h0, !val}, {31'h0, val});
            stop_test();
        end
    endtask
    task automatic pulse_clear();
        oc_clear <= 1'b1;
        cyc(1);
        oc_clear <= 1'b0;
    endtask
    task automatic pop_stream(input int halves, output logic [32:0] last, output int npop, output int novr);
        npop = 0;
        novr = 0;
        repeat (halves * HALF) begin
            @(posedge i_clk);
            if (res_valid === 1'b1 && res_ready === 1'b1) begin
                last = {res_ch2, res_rel, res_per};
                npop++;
            end
            if (overrun === 1'b1) begin
                novr++;
            end
        end
    endtask
    task automatic t_duty();
        int vt[6] = '{0, 100, -100, 250, -250, 300};
        logic [32:0] w;
        int np, no, d, e;
        foreach (vt[i]) begin
            d = 200 - (vt[i] * 400) / 1000;
            d = (d < 100) ? 100 : ((d > 300) ? 300 : d);
            e = HALF * d / 1000;
            vin_mv <= 12'(vt[i]);
            res_ready <= 1'b1;
            pop_stream(3, w, np, no);
            check(w[15:0], HALF);
            check(int'(w[31:16]) >= e - 3 && int'(w[31:16]) <= e + 3, 1);
            check(no, 0);
        end
        $display("duty test done");
    endtask
    // stalled receiver: buffer fills, extra words drop, two remain
    task automatic t_buffer();
        logic [32:0] a, b;
        int np, no;
        res_ready <= 1'b0;
        pop_stream(4, a, np, no);
        check(no >= 1, 1);
        res_ready <= 1'b1;
        np = 0;
        repeat (4) begin
            @(posedge i_clk);
            if (res_valid === 1'b1) begin
                b = a;
                a = {res_ch2, res_rel, res_per};
                np++;
            end
        end
        check(np, 2);
        check(a[32] ^ b[32], 1);
        check(res_valid, 0);
        $display("buffer test done");
    endtask
    task automatic t_oc();
        logic s0;
        vin_mv <= 12'sh1f4;
        cyc(430);
        vin_mv <= 12'sh000;
        cyc(5);
        vin_mv <= 12'sh1f4;
        cyc(430);
        check(link.flag_oe, 0);
        wait_flag(1'b0, 1'b1, 20);
        cyc(3);
        check({link.pwm_dev_oe, link.pwm_line, oc_flag, oc_latched}, 4'h7);
        pulse_clear();
        wait_flag(1'b0, 1'b0, 80);
        s0 = link.sync;
        wait_flag(1'b0, 1'b1, HALF + 5);
        check(link.sync !== s0, 1);
        vin_mv <= 12'sh000;
        pulse_clear();
        wait_flag(1'b0, 1'b0, 80);
        cyc(2 * HALF);
        check(link.flag_oe, 0);
        $display("overcurrent test done");
    endtask
    task automatic t_tied();
        vin2_mv <= -12'sh1f4;
        wait_flag(1'b1, 1'b1, 460);
        wait_flag(1'b1, 1'b0, 80);
        wait_flag(1'b1, 1'b1, HALF + 5);
        vin2_mv <= 12'sh000;
        wait_flag(1'b1, 1'b0, 80);
        cyc(2 * HALF);
        check({link2.flag_oe, oc_latched2}, 2'h0);
        $display("autoclear test done");
    endtask
    initial begin
        cyc(20);
        i_rst <= 1'b0;
        cyc(HALF / 2 + 2 * HALF);
        t_duty();
        t_buffer();
        t_oc();
        t_tied();
        stop_test();
    end
endmodule
`default_nettype wire

// ---- test/sense_link_properties.sv ----
// assertion checker for the sensor link
`default_nettype none
module sense_link_properties #(
    parameter int HALF = 312
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic sync,
    input wire logic pwm_dev_oe,
    input wire logic pwm_host_oe,
    input wire logic flag_oe,
    input wire logic pwm_line,
    input wire logic flag_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sync_d;
    logic [1:0] hc;
    int scnt;
    int rcnt;
    int lcnt;
    int hcnt;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // hc counts clean halves, so partial halves after reset or a fault are skipped
    always_ff @(posedge i_clk) begin
        sync_d <= sync;
        if (i_rst) begin
            scnt <= 0;
            hc <= 2'd0;
            rcnt <= 0;
            lcnt <= 0;
            hcnt <= 0;
        end else begin
            scnt <= (sync != sync_d) ? 0 : scnt + 1;
            if (flag_oe) begin
                hc <= 2'd0;
            end else if (sync != sync_d && hc != 2'd3) begin
                hc <= hc + 2'd1;
            end
            rcnt <= pwm_dev_oe ? 0 : rcnt + 1;
            lcnt <= (flag_oe && !pwm_line) ? lcnt + 1 : 0;
            hcnt <= pwm_host_oe ? hcnt + 1 : 0;
        end
    end
    a_flag_releases_duty: assert property (flag_oe |-> !pwm_dev_oe)
        else $error("duty sink while flagged");
    a_half_release_start: assert property ((sync != sync_d) |-> ##2 !pwm_dev_oe)
        else $error("half did not start released");
    a_release_in_range: assert property ($rose(pwm_dev_oe) && hc == 2'd3 |-> rcnt >= 30 && rcnt <= 95)
        else $error("released time out of range");
    a_sink_holds: assert property (pwm_dev_oe && !flag_oe && scnt >= 2 && scnt < HALF - 4
        |=> pwm_dev_oe || flag_oe)
        else $error("sink dropped mid half");
    a_sync_half_len: assert property ((sync != sync_d) && hc != 2'd0 |-> scnt >= HALF - 2 && scnt <= HALF + 1)
        else $error("alignment half length wrong");
    a_clear_after_pulse: assert property ($fell(flag_oe) |-> lcnt >= 62)
        else $error("flag cleared too early");
    a_clear_bounded: assert property (lcnt <= 66)
        else $error("flag not cleared by low pulse");
    a_host_pulse_len: assert property ($fell(pwm_host_oe) |-> hcnt >= 63 && hcnt <= 68)
        else $error("clear pulse length wrong");
    a_line_levels: assert property (pwm_line == !(pwm_dev_oe || pwm_host_oe) && flag_line == !flag_oe)
        else $error("open drain level wrong");
endmodule
`default_nettype wire

// ---- verilog/motor_ctrl_end.sv ----
// controller end: alignment generator, duty capture, flag clear pulse
`default_nettype none
module motor_ctrl_end #(
    parameter int CNT_W = 16,
    parameter int SYNC_HZ = sense_pkg::SYNC_HZ_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_rst,
    sense_link_if.host link,
    input wire logic i_oc_clear,
    output logic o_oc_flag,
    output logic o_res_valid,
    input wire logic i_res_ready,
    output logic o_res_channel_two,
    output logic [CNT_W-1:0] o_res_released,
    output logic [CNT_W-1:0] o_res_period,
    output logic o_overrun
);
    localparam int HALF_CYC = sense_pkg::NS_PER_S / (sense_pkg::CLK_NS * 2 * SYNC_HZ);
    localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);
    localparam int CLR_W = $clog2(sense_pkg::OC_CLEAR_DRIVE_CYC + 1);
    localparam int RES_W = 1 + 2 * CNT_W;

    typedef struct packed {
        logic [CNT_W-1:0] div_cnt;
        logic sync;
        logic [CLR_W-1:0] clr_cnt;
        logic [CNT_W-1:0] rel_cnt;
        logic [CNT_W-1:0] prev_len;
        logic prev_ch_two;
        logic have_prev;
        logic overrun;
    } host_state_type;

    host_state_type s_r;
    host_state_type s_nxt;
    logic toggle;
    logic push;
    logic in_ready;
    logic [RES_W-1:0] res_out;

    assign toggle = (s_r.div_cnt == HALF_LAST);
    // result of half n: released in half n+1 over length of half n
    assign push = toggle && s_r.have_prev;

    always_comb begin
        s_nxt = s_r;
        s_nxt.overrun = 1'b0;
        if (toggle) begin
            s_nxt.div_cnt = '0;
            s_nxt.sync = !s_r.sync;
            s_nxt.prev_len = HALF_LAST + 1'b1;
            s_nxt.prev_ch_two = !s_r.sync;
            s_nxt.have_prev = 1'b1;
            s_nxt.rel_cnt = '0;
            // the link cannot be stalled, so a full buffer drops the word
            s_nxt.overrun = push && !in_ready;
        end else begin
            s_nxt.div_cnt = s_r.div_cnt + 1'b1;
        end
        if (link.pwm_line && !toggle) begin
            s_nxt.rel_cnt = s_r.rel_cnt + 1'b1;
        end
        if (i_oc_clear && s_r.clr_cnt == '0) begin
            s_nxt.clr_cnt = CLR_W'(sense_pkg::OC_CLEAR_DRIVE_CYC);
        end else if (s_r.clr_cnt != '0) begin
            s_nxt.clr_cnt = s_r.clr_cnt - 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    two_entry_buffer #(
        .W(RES_W)
    ) u_res_buf (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_in_valid(push),
        .o_in_ready(in_ready),
        .i_in_data({s_r.prev_ch_two, s_r.rel_cnt, s_r.prev_len}),
        .o_out_valid(o_res_valid),
        .i_out_ready(i_res_ready),
        .o_out_data(res_out)
    );

    // per-channel tagging lets software keep separate offsets
    assign o_res_channel_two = res_out[RES_W-1];
    assign o_res_released = res_out[2*CNT_W-1:CNT_W];
    assign o_res_period = res_out[CNT_W-1:0];
    assign link.sync = s_r.sync;
    assign link.pwm_host_oe = (s_r.clr_cnt != '0);
    assign o_oc_flag = !link.flag_line;
    assign o_overrun = s_r.overrun;
endmodule
`default_nettype wire

// ---- verilog/pwm_current_sensor.sv ----
// sensor end: duty-coded current report and latched over-current flag
// Function
// - alignment input is the only timing reference
// - active-low output, duty = released(n+1)/period(n)
// - duty held between 10% and 30%, zero gives 20%
// - one result per alignment half, two per period
// - each half's released time scaled by the length of the half before
// - controller tags each result with its channel
// - sustained trip sets and latches low flag
// - external low pulse of 0.5 us clears flag
// - flagged device releases the duty output
// - persisting trip re-flags at next alignment edge
// - flag tied to output clears itself
// - both outputs open-drain, pulled up outside
// - duty = 20% minus 40%/V times input
`default_nettype none
module pwm_current_sensor #(
    parameter int CNT_W = 16,
    parameter int VIN_W = 12,
    parameter int TRIP_MV = sense_pkg::TRIP_MV_DEFAULT
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic signed [VIN_W-1:0] i_vin_mv,
    sense_link_if.device link,
    output logic o_oc_latched,
    output logic o_channel_two
);
    localparam int QUAL_W = $clog2(sense_pkg::OC_QUALIFY_CYC + 1);
    localparam int CLR_W = $clog2(sense_pkg::OC_CLEAR_PULSE_CYC + 1);
    localparam logic [QUAL_W-1:0] QUAL_DONE = QUAL_W'(sense_pkg::OC_QUALIFY_CYC);
    localparam logic [CLR_W-1:0] CLR_DONE = CLR_W'(sense_pkg::OC_CLEAR_PULSE_CYC);
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    typedef struct packed {
        logic sync_d;
        logic started;
        logic measured;
        logic [CNT_W-1:0] phase_cnt;
        logic [CNT_W-1:0] release_cnt;
        logic [QUAL_W-1:0] qual_cnt;
        logic [CLR_W-1:0] clr_cnt;
        logic oc_flag;
        logic pwm_oe;
        logic flag_oe;
    } dev_state_type;

    dev_state_type s_r;
    dev_state_type s_nxt;

    logic sync_edge;
    logic trip;
    logic set_new;
    logic set_again;
    logic set_oc;
    logic clr_oc;
    int vin_i;
    int duty_pm;
    int length_i;
    int release_i;

    // the alignment level is sampled like any other input
    assign sync_edge = (link.sync != s_r.sync_d);

    // magnitude compare on both signs
    assign trip = (int'(i_vin_mv) > TRIP_MV) || (int'(i_vin_mv) < -TRIP_MV);

    // duty code from the present input sample
    always_comb begin
        vin_i = int'(i_vin_mv);
        duty_pm = sense_pkg::DUTY_ZERO_PM
            - (vin_i * sense_pkg::GAIN_PM_PER_V) / sense_pkg::MV_PER_V;
        if (duty_pm < sense_pkg::DUTY_MIN_PM) begin
            duty_pm = sense_pkg::DUTY_MIN_PM;
        end
        if (duty_pm > sense_pkg::DUTY_MAX_PM) begin
            duty_pm = sense_pkg::DUTY_MAX_PM;
        end
    end

    // released time for the next half, scaled by the half just ended
    always_comb begin
        length_i = int'(s_r.phase_cnt) + 1;
        release_i = (length_i * duty_pm) / sense_pkg::PM_SCALE;
    end

    // first qualified cycle, or a re-flag on an alignment edge
    assign set_new = trip && (s_r.qual_cnt == QUAL_DONE - 1'b1);
    assign set_again = trip && (s_r.qual_cnt == QUAL_DONE) && sync_edge && !s_r.oc_flag;
    assign set_oc = set_new || set_again;

    // the device never sinks the output while flagged, so a low is external
    // or comes from a tied flag pin
    assign clr_oc = s_r.oc_flag && !link.pwm_line
        && (s_r.clr_cnt == CLR_DONE - 1'b1);

    always_comb begin
        s_nxt = s_r;
        s_nxt.sync_d = link.sync;

        // half-period measurement
        if (sync_edge) begin
            s_nxt.phase_cnt = '0;
            s_nxt.started = 1'b1;
            // a partial first half is never reported
            s_nxt.measured = s_r.started;
            if (release_i > int'(CNT_MAX)) begin
                s_nxt.release_cnt = CNT_MAX;
            end else begin
                s_nxt.release_cnt = CNT_W'(release_i);
            end
        end else if (s_r.phase_cnt != CNT_MAX) begin
            s_nxt.phase_cnt = s_r.phase_cnt + 1'b1;
        end

        // qualification timer
        if (!trip) begin
            s_nxt.qual_cnt = '0;
        end else if (s_r.qual_cnt != QUAL_DONE) begin
            s_nxt.qual_cnt = s_r.qual_cnt + 1'b1;
        end

        // clear-pulse width counter
        if (s_r.oc_flag && !link.pwm_line) begin
            if (s_r.clr_cnt != CLR_DONE) begin
                s_nxt.clr_cnt = s_r.clr_cnt + 1'b1;
            end
        end else begin
            s_nxt.clr_cnt = '0;
        end

        // latch: a new set wins over a clear in the same cycle
        if (set_oc) begin
            s_nxt.oc_flag = 1'b1;
        end else if (clr_oc) begin
            s_nxt.oc_flag = 1'b0;
            s_nxt.clr_cnt = '0;
        end

        // pin drivers, sink only, pull-ups are outside
        s_nxt.flag_oe = s_nxt.oc_flag;
        s_nxt.pwm_oe = !s_nxt.oc_flag && s_nxt.measured
            && (s_nxt.phase_cnt >= s_nxt.release_cnt);
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.pwm_dev_oe = s_r.pwm_oe;
    assign link.flag_oe = s_r.flag_oe;
    assign o_oc_latched = s_r.oc_flag;
    // low alignment level is channel two
    assign o_channel_two = !s_r.sync_d;
endmodule
`default_nettype wire

// ---- verilog/sense_link_if.sv ----
// open-drain link between current sensor and motor controller
`default_nettype none
interface sense_link_if #(
    parameter bit TIED = 1'b0
);
    logic sync;
    logic pwm_dev_oe;
    logic pwm_host_oe;
    logic flag_oe;
    logic pwm_line;
    logic flag_line;
    // pull-ups hold both lines high unless someone sinks them
    assign pwm_line = !(pwm_dev_oe || pwm_host_oe || (TIED && flag_oe));
    assign flag_line = !(flag_oe || (TIED && (pwm_dev_oe || pwm_host_oe)));
    modport device (
        input sync,
        input pwm_line,
        input flag_line,
        output pwm_dev_oe,
        output flag_oe
    );
    modport host (
        output sync,
        output pwm_host_oe,
        input pwm_line,
        input flag_line
    );
endinterface
`default_nettype wire

// ---- verilog/sense_pkg.sv ----
// shared constants for the current sensor device and its controller
`default_nettype none
package sense_pkg;
    localparam int CLK_NS = 8;
    localparam int OC_QUALIFY_NS = 3500;
    localparam int OC_QUALIFY_CYC = (OC_QUALIFY_NS + CLK_NS - 1) / CLK_NS;
    localparam int OC_CLEAR_PULSE_NS = 500;
    localparam int OC_CLEAR_PULSE_CYC = (OC_CLEAR_PULSE_NS + CLK_NS - 1) / CLK_NS;
    // controller holds the pin low a little longer than the least time
    localparam int OC_CLEAR_DRIVE_CYC = OC_CLEAR_PULSE_CYC + 4;
    localparam int PM_SCALE = 1000;
    localparam int DUTY_ZERO_PM = 200;
    localparam int DUTY_MIN_PM = 100;
    localparam int DUTY_MAX_PM = 300;
    localparam int GAIN_PM_PER_V = 400;
    localparam int MV_PER_V = 1000;
    localparam int TRIP_MV_DEFAULT = 400;
    localparam int SYNC_HZ_DEFAULT = 20000;
    localparam int NS_PER_S = 1000000000;
endpackage
`default_nettype wire

// ---- verilog/two_entry_buffer.sv ----
// two-entry valid/ready buffer
`default_nettype none
module two_entry_buffer #(
    parameter int W = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data
);
    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] count;
    } buf_state_type;

    buf_state_type s_r;
    buf_state_type s_nxt;
    logic push;
    logic pop;

    assign o_in_ready = (s_r.count != 2'h2);
    assign o_out_valid = (s_r.count != 2'h0);
    assign o_out_data = s_r.mem[s_r.rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wr_ptr] = i_in_data;
            s_nxt.wr_ptr = !s_r.wr_ptr;
        end
        if (pop) begin
            s_nxt.rd_ptr = !s_r.rd_ptr;
        end
        s_nxt.count = s_r.count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule
`default_nettype wire
